// ### hw/csb_map.svh
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

// status register bit positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_H 5

// widths
`define CSB_PC_W 16
`define CSB_OFF_W 7

// reset values
`define CSB_PC_RST 16'h0000
`define CSB_STATUS_RST 8'h00

// program counter steps
`define CSB_STEP_SEQ 16'h0001
`define CSB_STEP_SKIP_ONE 16'h0002
`define CSB_STEP_SKIP_TWO 16'h0003

// cycle counts
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_THREE 2'h3

`endif

// ### hw/csb_pkg.sv
package csb_pkg;

   // operations handled by the unit
   typedef enum logic [3:0] {
      csb_nop_op,
      compare_immediate_op,
      compare_skip_equal_op,
      skip_reg_bit_clear_op,
      skip_reg_bit_set_op,
      skip_io_bit_clear_op,
      skip_io_bit_set_op,
      branch_flag_set_op,
      branch_flag_clear_op,
      branch_equal_op,
      branch_not_equal_op,
      branch_carry_set_op,
      branch_carry_clear_op
   } csb_op_t;

   // sequencer states
   typedef enum logic {
      csb_idle,
      csb_run
   } csb_state_t;

endpackage

// ### hw/csb_cmp.sv
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"

module csb_cmp (
   // operands
   input wire logic [7:0] i_dst,
   input wire logic [7:0] i_imm,
   input wire logic [7:0] i_status,
   // flags after the compare
   output logic [7:0] o_status
);

   logic [7:0] diff;

   // difference is only used for flags, never stored
   always_comb begin
      diff = i_dst - i_imm;
      o_status = i_status;
      o_status[`CSB_FLAG_Z] = (diff == 8'h00);
      o_status[`CSB_FLAG_N] = diff[7];
      o_status[`CSB_FLAG_V] = (i_dst[7] & ~i_imm[7] & ~diff[7])
         | (~i_dst[7] & i_imm[7] & diff[7]);
      o_status[`CSB_FLAG_C] = (~i_dst[7] & i_imm[7]) | (i_imm[7] & diff[7])
         | (diff[7] & ~i_dst[7]);
      o_status[`CSB_FLAG_H] = (~i_dst[3] & i_imm[3]) | (i_imm[3] & diff[3])
         | (diff[3] & ~i_dst[3]);
   end

endmodule

`default_nettype wire

// ### hw/csb_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"

module csb_unit (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // instruction issue
   input wire logic i_valid,
   input wire csb_pkg::csb_op_t i_op,
   input wire logic [`CSB_PC_W-1:0] i_pc,
   // operands
   input wire logic [7:0] i_dst_val,
   input wire logic [7:0] i_source_register,
   input wire logic [7:0] i_imm,
   input wire logic [7:0] i_io_val,
   input wire logic [2:0] i_bit_sel,
   input wire logic [`CSB_OFF_W-1:0] i_offset,
   input wire logic i_next_two_word,
   // current status register
   input wire logic [7:0] i_status_register,
   // results
   output logic o_busy,
   output logic o_done,
   output logic o_pc_load,
   output logic [`CSB_PC_W-1:0] o_pc,
   output logic o_status_we,
   output logic [7:0] o_status
);

   csb_pkg::csb_state_t state;
   logic [1:0] rem;
   logic [1:0] cyc_calc;
   logic take;
   logic is_skip;
   logic is_branch;
   logic [`CSB_PC_W-1:0] next_pc;
   logic [7:0] cmp_status;
   logic [`CSB_PC_W-1:0] res_pc;
   logic [7:0] res_status;
   logic res_we;
   logic accept;

   // pick one bit of a byte
   function automatic logic bit_of(input logic [7:0] v, input logic [2:0] b);
      bit_of = v[b];
   endfunction

   // relative target: pc + signed offset + 1
   function automatic logic [`CSB_PC_W-1:0] rel_target(
      input logic [`CSB_PC_W-1:0] pc, input logic [`CSB_OFF_W-1:0] k);
      logic [`CSB_PC_W-1:0] sk;
      sk = {{(`CSB_PC_W-`CSB_OFF_W){k[`CSB_OFF_W-1]}}, k};
      rel_target = pc + sk + `CSB_STEP_SEQ;
   endfunction

   assign accept = i_valid && !o_busy;

   csb_cmp csb_cmp_inst (
      .i_dst(i_dst_val),
      .i_imm(i_imm),
      .i_status(i_status_register),
      .o_status(cmp_status)
   );

   // condition decode for every op
   always_comb begin
      take = 1'b0;
      is_skip = 1'b0;
      is_branch = 1'b0;
      unique case (i_op)
         csb_pkg::compare_skip_equal_op: begin
            is_skip = 1'b1;
            take = (i_dst_val == i_source_register);
         end
         csb_pkg::skip_reg_bit_clear_op: begin
            is_skip = 1'b1;
            take = !bit_of(i_source_register, i_bit_sel);
         end
         csb_pkg::skip_reg_bit_set_op: begin
            is_skip = 1'b1;
            take = bit_of(i_source_register, i_bit_sel);
         end
         csb_pkg::skip_io_bit_clear_op: begin
            is_skip = 1'b1;
            take = !bit_of(i_io_val, i_bit_sel);
         end
         csb_pkg::skip_io_bit_set_op: begin
            is_skip = 1'b1;
            take = bit_of(i_io_val, i_bit_sel);
         end
         csb_pkg::branch_flag_set_op: begin
            is_branch = 1'b1;
            take = bit_of(i_status_register, i_bit_sel);
         end
         csb_pkg::branch_flag_clear_op: begin
            is_branch = 1'b1;
            take = !bit_of(i_status_register, i_bit_sel);
         end
         csb_pkg::branch_equal_op: begin
            is_branch = 1'b1;
            take = i_status_register[`CSB_FLAG_Z];
         end
         csb_pkg::branch_not_equal_op: begin
            is_branch = 1'b1;
            take = !i_status_register[`CSB_FLAG_Z];
         end
         csb_pkg::branch_carry_set_op: begin
            is_branch = 1'b1;
            take = i_status_register[`CSB_FLAG_C];
         end
         csb_pkg::branch_carry_clear_op: begin
            is_branch = 1'b1;
            take = !i_status_register[`CSB_FLAG_C];
         end
         default: begin
            take = 1'b0;
         end
      endcase
   end

   // new pc and cycle count
   always_comb begin
      next_pc = i_pc + `CSB_STEP_SEQ;
      cyc_calc = `CSB_CYC_ONE;
      if (is_skip && take) begin
         // skipped length decides step and cost
         next_pc = i_pc + (i_next_two_word ? `CSB_STEP_SKIP_TWO : `CSB_STEP_SKIP_ONE);
         cyc_calc = i_next_two_word ? `CSB_CYC_THREE : `CSB_CYC_TWO;
      end else if (is_branch && take) begin
         next_pc = rel_target(i_pc, i_offset);
         cyc_calc = `CSB_CYC_TWO;
      end
   end

   // results held until the last cycle of the op
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         res_pc <= `CSB_PC_RST;
         res_status <= `CSB_STATUS_RST;
         res_we <= 1'b0;
      end else if (accept) begin
         res_pc <= next_pc;
         res_we <= (i_op == csb_pkg::compare_immediate_op);
         // all other ops hand back the flags untouched
         res_status <= (i_op == csb_pkg::compare_immediate_op) ? cmp_status
            : i_status_register;
      end
   end

   // cycle sequencer; busy stalls the issue side
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= csb_pkg::csb_idle;
         rem <= 2'h0;
         o_busy <= 1'b0;
      end else begin
         unique case (state)
            csb_pkg::csb_idle: begin
               if (accept) begin
                  state <= csb_pkg::csb_run;
                  rem <= cyc_calc - 2'h1;
                  o_busy <= 1'b1;
               end
            end
            csb_pkg::csb_run: begin
               if (rem == 2'h0) begin
                  state <= csb_pkg::csb_idle;
                  o_busy <= 1'b0;
               end else begin
                  rem <= rem - 2'h1;
               end
            end
         endcase
      end
   end

   // result outputs, one-cycle strobes on completion
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_done <= 1'b0;
         o_pc_load <= 1'b0;
         o_pc <= `CSB_PC_RST;
         o_status_we <= 1'b0;
         o_status <= `CSB_STATUS_RST;
      end else begin
         o_done <= 1'b0;
         o_pc_load <= 1'b0;
         o_status_we <= 1'b0;
         if (state == csb_pkg::csb_run && rem == 2'h0) begin
            o_done <= 1'b1;
            o_pc_load <= 1'b1;
            o_pc <= res_pc;
            o_status_we <= res_we;
            o_status <= res_status;
         end
      end
   end

   // checking helpers: raw issue values and elapsed cycles
   csb_pkg::csb_op_t chk_op;
   logic [`CSB_PC_W-1:0] chk_pc;
   logic [7:0] chk_st;
   logic [7:0] chk_a;
   logic [7:0] chk_b;
   logic [7:0] chk_imm;
   logic [7:0] chk_io;
   logic [2:0] chk_bit;
   logic [`CSB_OFF_W-1:0] chk_off;
   logic chk_two;
   logic [2:0] chk_cyc;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         chk_op <= csb_pkg::csb_nop_op;
         chk_pc <= `CSB_PC_RST;
         chk_st <= 8'h00;
         chk_a <= 8'h00;
         chk_b <= 8'h00;
         chk_imm <= 8'h00;
         chk_io <= 8'h00;
         chk_bit <= 3'h0;
         chk_off <= 7'h00;
         chk_two <= 1'b0;
         chk_cyc <= 3'h0;
      end else if (accept) begin
         chk_op <= i_op;
         chk_pc <= i_pc;
         chk_st <= i_status_register;
         chk_a <= i_dst_val;
         chk_b <= i_source_register;
         chk_imm <= i_imm;
         chk_io <= i_io_val;
         chk_bit <= i_bit_sel;
         chk_off <= i_offset;
         chk_two <= i_next_two_word;
         chk_cyc <= 3'h0; // counts busy edges, so it reads the op's cycles at done
      end else if (o_busy) begin
         chk_cyc <= chk_cyc + 3'h1;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   AST_CMP_IMM: assert property (
      o_done && chk_op == csb_pkg::compare_immediate_op |-> chk_cyc == 3'h1 && o_status_we
      && o_status[`CSB_FLAG_Z] == (chk_a == chk_imm) && o_status[`CSB_FLAG_C] == (chk_a < chk_imm)
      && o_pc == chk_pc + 16'h0001)
      else $error("compare immediate result wrong");
   AST_CMP_SKIP: assert property (
      o_done && chk_op == csb_pkg::compare_skip_equal_op && chk_a == chk_b
      |-> o_pc != chk_pc + 16'h0001 && o_status == chk_st && !o_status_we)
      else $error("compare skip did not skip");
   AST_SKIP_REG_CLR: assert property (
      o_done && chk_op == csb_pkg::skip_reg_bit_clear_op
      |-> (o_pc == chk_pc + 16'h0001) == chk_b[chk_bit] && !o_status_we)
      else $error("register bit clear skip wrong");
   AST_SKIP_REG_SET: assert property (
      o_done && chk_op == csb_pkg::skip_reg_bit_set_op
      |-> (o_pc == chk_pc + 16'h0001) == !chk_b[chk_bit] && !o_status_we)
      else $error("register bit set skip wrong");
   AST_SKIP_IO_CLR: assert property (
      o_done && chk_op == csb_pkg::skip_io_bit_clear_op
      |-> (o_pc == chk_pc + 16'h0001) == chk_io[chk_bit])
      else $error("io bit clear skip wrong");
   AST_SKIP_IO_SET: assert property (
      o_done && chk_op == csb_pkg::skip_io_bit_set_op
      |-> (o_pc == chk_pc + 16'h0001) == !chk_io[chk_bit])
      else $error("io bit set skip wrong");
   AST_BR_FLAG_SET: assert property (
      o_done && chk_op == csb_pkg::branch_flag_set_op && chk_st[chk_bit]
      |-> chk_cyc == 3'h2 && o_pc == chk_pc + {{9{chk_off[6]}}, chk_off} + 16'h0001)
      else $error("branch on flag set wrong");
   AST_BR_FLAG_CLR: assert property (
      o_done && chk_op == csb_pkg::branch_flag_clear_op
      |-> chk_cyc == (chk_st[chk_bit] ? 3'h1 : 3'h2) && o_status == chk_st)
      else $error("branch on flag clear wrong");
   AST_BR_EQ: assert property (
      o_done && chk_op == csb_pkg::branch_equal_op && !chk_st[`CSB_FLAG_Z]
      |-> o_pc == chk_pc + 16'h0001 && chk_cyc == 3'h1)
      else $error("branch equal taken with Z clear");
   AST_BR_NE: assert property (
      o_done && chk_op == csb_pkg::branch_not_equal_op && chk_st[`CSB_FLAG_Z]
      |-> o_pc == chk_pc + 16'h0001)
      else $error("branch not equal taken with Z set");
   AST_BR_CC: assert property (
      o_done && chk_op == csb_pkg::branch_carry_clear_op && chk_st[`CSB_FLAG_C]
      |-> o_pc == chk_pc + 16'h0001)
      else $error("branch carry clear taken with C set");
   AST_BR_CS: assert property (
      accept && i_op == csb_pkg::branch_carry_set_op && i_status_register[`CSB_FLAG_C]
      |-> ##1 !o_done ##1 !o_done ##1 o_done && !o_status_we && o_status == chk_st)
      else $error("branch carry set timing or flags wrong");
   AST_SKIP_LEN: assert property (
      o_done && chk_op != csb_pkg::compare_immediate_op && o_pc == chk_pc + 16'h0003
      && chk_op inside {csb_pkg::compare_skip_equal_op, csb_pkg::skip_io_bit_set_op,
      csb_pkg::skip_reg_bit_clear_op, csb_pkg::skip_reg_bit_set_op,
      csb_pkg::skip_io_bit_clear_op} |-> chk_two && chk_cyc == 3'h3)
      else $error("skip step and length disagree");

   COV_CMP_IMM: cover property (o_done && o_status_we);
   COV_SKIP_TWO: cover property (o_done && chk_cyc == 3'h3);
   COV_BRANCH: cover property (o_done && chk_cyc == 3'h2 && chk_op == csb_pkg::branch_equal_op);

endmodule

`default_nettype wire

// ### tb/csb_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none
module csb_unit_bench;
   logic i_sys_clk, i_rst, i_valid, i_next_two_word;
   csb_pkg::csb_op_t i_op;
   logic [15:0] i_pc;
   logic [7:0] i_dst_val, i_source_register, i_imm, i_io_val, i_status_register;
   logic [2:0] i_bit_sel;
   logic [6:0] i_offset;
   logic o_busy, o_done, o_pc_load, o_status_we;
   logic [15:0] o_pc;
   logic [7:0] o_status;
   int n_mismatch, tests_run;
   // operand pairs for the compare: equal, half borrow, full borrow, overflow
   localparam logic [7:0] DT [4] = '{8'h05, 8'h10, 8'h00, 8'h80};
   localparam logic [7:0] KT [4] = '{8'h05, 8'h01, 8'h01, 8'h01};

   csb_unit csb_unit_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_valid(i_valid),
      .i_op(i_op), .i_pc(i_pc), .i_dst_val(i_dst_val), .i_source_register(i_source_register),
      .i_imm(i_imm), .i_io_val(i_io_val), .i_bit_sel(i_bit_sel), .i_offset(i_offset),
      .i_next_two_word(i_next_two_word), .i_status_register(i_status_register),
      .o_busy(o_busy), .o_done(o_done), .o_pc_load(o_pc_load), .o_pc(o_pc),
      .o_status_we(o_status_we), .o_status(o_status));

   // 25 MHz core clock
   always #20 i_sys_clk = ~i_sys_clk;

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // expected flags of dst minus imm; untouched bits pass through
   function automatic logic [7:0] f_cmp(input logic [7:0] d, input logic [7:0] k,
      input logic [7:0] s);
      logic [7:0] r;
      logic [7:0] o;
      r = d - k;
      o = s;
      o[0] = (~d[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~d[7]);
      o[1] = (r == 8'h00);
      o[2] = r[7];
      o[3] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
      o[5] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
      return o;
   endfunction

   // issue one op, wait for done, judge pc, flags, strobes and cycle count
   task automatic run_op(input csb_pkg::csb_op_t op, input logic [15:0] pc,
      input logic [7:0] dv, input logic [7:0] sv, input logic [7:0] io, input logic [7:0] st,
      input logic [2:0] bs, input logic [6:0] off, input logic tw, input logic hold,
      input logic [15:0] epc, input logic [7:0] est, input logic [7:0] ecyc);
      logic [7:0] k;
      logic cmp;
      cmp = (op == csb_pkg::compare_immediate_op);
      @(posedge i_sys_clk);
      i_valid <= 1'b1;
      i_op <= op;
      i_pc <= pc;
      i_dst_val <= dv;
      // the unused operand gets the inverse so a wrong source shows up
      i_imm <= cmp ? sv : ~sv;
      i_source_register <= cmp ? ~sv : sv;
      i_io_val <= io;
      i_status_register <= st;
      i_bit_sel <= bs;
      i_offset <= off;
      i_next_two_word <= tw;
      @(posedge i_sys_clk);
      // hold keeps a different request up while busy; it must be ignored
      if (hold) i_op <= csb_pkg::compare_immediate_op;
      else i_valid <= 1'b0;
      for (k = 8'h01; k <= 8'h08; k++) begin
         @(posedge i_sys_clk);
         i_valid <= 1'b0;
         #1;
         if (o_done === 1'b1) break;
      end
      if (k > 8'h08) begin
         n_mismatch++;
         test_done();
      end
      chk8(k, ecyc);
      chk16(o_pc, epc);
      chk8(o_status, est);
      chk8({5'h00, o_busy, o_pc_load, o_status_we}, {6'h00, 1'b1, cmp});
      if (hold) begin
         @(posedge i_sys_clk);
         #1;
         chk8({6'h00, o_done, o_busy}, 8'h00);
      end
   endtask

   task automatic t_compare();
      int i;
      logic [7:0] st;
      for (i = 0; i < 4; i++) begin
         st = i[0] ? 8'hD0 : 8'h2F;
         run_op(csb_pkg::compare_immediate_op, 16'h0100, DT[i], KT[i], 8'h00, st, 3'h0, 7'h00,
            1'b0, 1'b0, 16'h0101, f_cmp(DT[i], KT[i], st), 8'h01);
      end
      $display("compare test ended");
   endtask

   task automatic t_skip();
      int j, b;
      logic tw, tk;
      logic [7:0] src;
      csb_pkg::csb_op_t op;
      run_op(csb_pkg::compare_skip_equal_op, 16'h0200, 8'h3C, 8'h3C, 8'h00, 8'h5A, 3'h0, 7'h00,
         1'b1, 1'b0, 16'h0203, 8'h5A, 8'h03);
      run_op(csb_pkg::compare_skip_equal_op, 16'h0200, 8'h3C, 8'h3C, 8'h00, 8'hA5, 3'h0, 7'h00,
         1'b0, 1'b0, 16'h0202, 8'hA5, 8'h02);
      run_op(csb_pkg::compare_skip_equal_op, 16'h0200, 8'h3C, 8'h3D, 8'h00, 8'h5A, 3'h0, 7'h00,
         1'b1, 1'b0, 16'h0201, 8'h5A, 8'h01);
      // register bits 0 and 7 set, i/o register holds the inverse
      for (j = 0; j < 4; j++) begin
         for (b = 0; b < 8; b += 3) begin
            op = csb_pkg::csb_op_t'(4'(j) + 4'h3);
            src = (j >= 2) ? 8'h7E : 8'h81;
            tk = (src[b] == j[0]);
            tw = b[0] ^ j[0];
            run_op(op, 16'h0400, 8'h00, 8'h81, 8'h7E, 8'h3C, 3'(b), 7'h00, tw, 1'b0,
               16'h0401 + (tk ? 16'h0001 + tw : 16'h0000), 8'h3C,
               tk ? 8'h02 + tw : 8'h01);
         end
      end
      $display("skip test ended");
   endtask

   task automatic t_branch();
      int j, b;
      logic tk, fl;
      logic [6:0] off;
      logic [7:0] st;
      csb_pkg::csb_op_t op;
      for (j = 0; j < 2; j++) begin
         for (b = 0; b < 8; b++) begin
            off = b[0] ? 7'h40 : 7'h3F;
            op = j[0] ? csb_pkg::branch_flag_clear_op : csb_pkg::branch_flag_set_op;
            st = 8'hA5;
            tk = st[b] ^ j[0];
            run_op(op, 16'h0010, 8'h00, 8'h00, 8'h00, 8'hA5, 3'(b), off, 1'b0, 1'b0,
               tk ? 16'h0011 + {{9{off[6]}}, off} : 16'h0011, 8'hA5,
               tk ? 8'h02 : 8'h01);
         end
      end
      // equal, not equal, carry set, carry clear against two status values
      for (j = 0; j < 8; j++) begin
         op = csb_pkg::csb_op_t'(4'(j >> 1) + 4'h9);
         st = j[0] ? 8'h02 : 8'h01;
         fl = (j < 4) ? st[1] : st[0];
         tk = (fl == ((j >> 1) % 2 == 0));
         run_op(op, 16'h0800, 8'h00, 8'h00, 8'h00, st, 3'h0, 7'h7E, 1'b0, 1'b0,
            tk ? 16'h07FF : 16'h0801, st, tk ? 8'h02 : 8'h01);
      end
      run_op(csb_pkg::branch_equal_op, 16'h0300, 8'h00, 8'h00, 8'h00, 8'h02, 3'h0, 7'h05,
         1'b0, 1'b1, 16'h0306, 8'h02, 8'h02);
      $display("branch test ended");
   endtask

   // main sequence: reset, then each group of operations
   initial begin
      i_sys_clk = 1'b0;
      i_rst = 1'b1;
      i_valid = 1'b0;
      i_op = csb_pkg::csb_nop_op;
      {i_pc, i_dst_val, i_source_register, i_imm, i_io_val} = '0;
      {i_status_register, i_bit_sel, i_offset, i_next_two_word} = '0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (4) @(posedge i_sys_clk);
      #1;
      chk16(o_pc, 16'h0000);
      chk8(o_status, 8'h00);
      chk8({4'h0, o_busy, o_done, o_pc_load, o_status_we}, 8'h00);
      @(posedge i_sys_clk);
      i_rst <= 1'b0;
      $display("reset test ended");
      t_compare();
      t_skip();
      t_branch();
      test_done();
   end
endmodule
`default_nettype wire
